// ==== dv/fbo_flash_model.sv ====
`timescale 1ns/1ps
module fbo_flash_model (
	input  wire        ref_clk,         // timing
	input  wire [21:0] address_pins,    // addr
	input  wire [7:0]  data_pins_o,     // wdata
	output reg  [7:0]  data_pins_i,     // rdata
	input  wire        chip_select_n,   // cs
	input  wire        output_enable_n, // oe
	input  wire        write_strobe_n,  // we
	input  wire        device_clear_n,  // clear
	output wire        ready_busy_n     // rdy
);
	parameter ID_CODE = 8'h5a; // arbitrary
	reg [1:0] mode_reg = 2'h0;
	reg [8:0] busy_reg = 9'h000;
	reg [7:0] pdata_reg = 8'h00;
	reg [7:0] junk_reg = 8'h00;
	reg [5:0] sect_reg = 6'h00;
	reg [3:0] acc_reg = 4'h0;
	reg       we_reg = 1'b1;
	assign ready_busy_n = (busy_reg == 9'h000);
	always @(posedge ref_clk) begin
		we_reg   <= write_strobe_n;
		junk_reg <= ~junk_reg;
		acc_reg  <= (chip_select_n | output_enable_n) ? 4'h0 : acc_reg + {3'h0, acc_reg != 4'hf};
		if (busy_reg != 9'h000) busy_reg <= busy_reg - 9'h001;
		if (!device_clear_n) begin
			mode_reg <= 2'h0;
			// idle clear ends at once; busy one lingers
			if (busy_reg > 9'h028) busy_reg <= 9'h028;
		end else if (write_strobe_n && !we_reg && !chip_select_n && ready_busy_n) begin
			// latch is unmapped, only the byte steers
			mode_reg <= mode_reg[1] ? 2'h0 :
				(data_pins_o == 8'h90) ? 2'h1 :
				(data_pins_o == 8'ha0) ? 2'h2 :
				(data_pins_o == 8'h80) ? 2'h3 : 2'h0;
			if (mode_reg == 2'h2) begin
				busy_reg  <= 9'h12c;
				pdata_reg <= data_pins_o;
				sect_reg  <= address_pins[21:16];
			end
			// armed erase: 30 one sector, 10 whole array
			if (mode_reg == 2'h3 &&
				(data_pins_o == 8'h30 || data_pins_o == 8'h10)) begin
				busy_reg  <= 9'h12c;
				pdata_reg <= 8'hff;
				sect_reg  <= address_pins[21:16];
			end
		end
	end
	// garbage until access time, so early sampling shows
	always @* begin
		if (!device_clear_n || chip_select_n || output_enable_n ||
			acc_reg < 4'hc) data_pins_i = junk_reg;
		else if (!ready_busy_n) data_pins_i = {~pdata_reg[7], 1'b0, sect_reg};
		else if (mode_reg == 2'h1) data_pins_i = ID_CODE;
		else data_pins_i = address_pins[7:0] ^ {2'h0, address_pins[21:16]};
	end
endmodule

// ==== dv/fbo_host_props.sv ====
`timescale 1ns/1ps
module fbo_host_props (
	input wire ref_clk,         // clock
	input wire reset,           // reset
	input wire busy_seen,       // busy
	input wire data_pins_oe,    // drive
	input wire chip_select_n,   // cs
	input wire output_enable_n, // oe
	input wire write_strobe_n,  // we
	input wire device_clear_n,  // clear
	input wire ready_busy_n     // rdy
);
	reg [7:0] oe_low_reg;
	reg [7:0] clr_low_reg;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			oe_low_reg  <= 8'h00;
			clr_low_reg <= 8'h00;
		end else begin
			oe_low_reg  <= output_enable_n ? 8'h00 : oe_low_reg + 8'h01;
			clr_low_reg <= device_clear_n ? 8'h00 : clr_low_reg + 8'h01;
		end
	end
	chk_read_levels: assert property (
		!output_enable_n |-> !chip_select_n && write_strobe_n && !data_pins_oe)
		else $error("read strobes wrong");
	chk_write_levels: assert property (
		!write_strobe_n |-> !chip_select_n && output_enable_n && data_pins_oe)
		else $error("write strobes wrong");
	chk_write_pulse: assert property (
		$fell(write_strobe_n) |-> (!write_strobe_n)[*6])
		else $error("write pulse short");
	chk_read_access: assert property (
		$rose(output_enable_n) |-> oe_low_reg >= 8'h0c)
		else $error("read ended before access time");
	chk_clear_width: assert property (
		$rose(device_clear_n) |-> clr_low_reg >= 8'h3f)
		else $error("clear pulse short");
	chk_clear_recovery: assert property (
		$rose(device_clear_n) |-> output_enable_n[*7])
		else $error("read inside recovery");
	chk_clear_quiet: assert property (
		!device_clear_n |-> chip_select_n && write_strobe_n && output_enable_n)
		else $error("access during clear");
	chk_busy_track: assert property (
		$fell(ready_busy_n) |-> ##[1:5] busy_seen)
		else $error("busy not seen");
	cover property ($rose(output_enable_n));
	cover property ($rose(write_strobe_n));
	cover property ($rose(device_clear_n) && busy_seen);
endmodule
bind fbo_host fbo_host_props fbo_host_props_i (.ref_clk(ref_clk),
	.reset(reset), .busy_seen(busy_seen), .data_pins_oe(data_pins_oe),
	.chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
	.write_strobe_n(write_strobe_n), .device_clear_n(device_clear_n),
	.ready_busy_n(ready_busy_n));

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
	reg         ref_clk = 1'b0;
	reg         reset = 1'b1;
	reg         req_valid = 1'b0;
	reg  [1:0]  req_op = 2'h0;
	reg  [21:0] req_addr = 22'h00_0000;
	reg  [7:0]  req_wdata = 8'h00;
	wire        req_ready, rsp_valid, busy_seen, aborted_op, data_pins_oe;
	wire [7:0]  rsp_rdata, data_pins_o, data_pins_i;
	wire [21:0] address_pins;
	wire        chip_select_n, output_enable_n, write_strobe_n;
	wire        device_clear_n, ready_busy_n;
	integer     n_mismatch = 0;
	integer     num_checks = 0;
	integer     seed = 32'h3dbc;
	integer     i;
	reg  [21:0] a;
	reg  [31:0] rnd;
	reg  [9:0]  note;
	reg  [9:0]  note_q[$];
	fbo_host fbo_host_i (.ref_clk(ref_clk), .reset(reset), .req_valid(req_valid),
		.req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.busy_seen(busy_seen), .aborted_op(aborted_op), .address_pins(address_pins),
		.data_pins_o(data_pins_o), .data_pins_oe(data_pins_oe),
		.data_pins_i(data_pins_i), .chip_select_n(chip_select_n),
		.output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
		.device_clear_n(device_clear_n), .ready_busy_n(ready_busy_n));
	fbo_flash_model fbo_flash_model_i (.ref_clk(ref_clk), .address_pins(address_pins),
		.data_pins_o(data_pins_o), .data_pins_i(data_pins_i),
		.chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
		.write_strobe_n(write_strobe_n), .device_clear_n(device_clear_n),
		.ready_busy_n(ready_busy_n));
	initial forever #4 ref_clk = ~ref_clk;
	function [7:0] arr(input [21:0] ad);
		arr = ad[7:0] ^ {2'h0, ad[21:16]};
	endfunction
	task check(input [7:0] seen, input [7:0] exp, input string what);
		num_checks = num_checks + 1;
		if (seen !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("Error %0s expected %h seen %h", what, exp, seen);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task wait_ready;
		integer k;
		for (k = 0; k < 2000 && req_ready !== 1'b1; k = k + 1) @(negedge ref_clk);
		if (k == 2000) begin
			n_mismatch = n_mismatch + 1;
			stop_test;
		end
	endtask
	task issue(input [1:0] op, input [21:0] ad, input [7:0] wd, input [7:0] ex);
		wait_ready;
		{req_op, req_addr, req_wdata, req_valid} = {op, ad, wd, 1'b1};
		note_q.push_back({op, (op == 2'h1) ? wd : ex});
		@(negedge ref_clk);
		req_valid = 1'b0;
	endtask
	always @(negedge ref_clk) begin
		if (rsp_valid === 1'b1) begin
			note = note_q.size() ? note_q.pop_front() : 10'h1ff;
			if (note[9:8] == 2'h0) check(rsp_rdata, note[7:0], "read data");
			else if (note[9]) check({7'h00, aborted_op}, note[7:0], "abort flag");
			else check(data_pins_o, note[7:0], "write answer");
		end
	end
	initial begin
		#100000;
		n_mismatch = n_mismatch + 1;
		stop_test;
	end
	initial begin
		note_q.push_back(10'h200);
		repeat (12) @(negedge ref_clk);
		reset = 1'b0;
		for (i = 0; i < 5; i = i + 1) begin
			rnd = $random(seed);
			a = (i == 4) ? 22'h3f_ffff : rnd[21:0];
			issue(2'h0, a, 8'h00, arr(a));
		end
		issue(2'h1, 22'h00_0555, 8'h90, 8'h00);
		issue(2'h0, 22'h00_0000, 8'h00, 8'h5a);
		issue(2'h1, 22'h00_0555, 8'hf0, 8'h00);
		issue(2'h0, 22'h00_0555, 8'h00, arr(22'h00_0555));
		issue(2'h1, 22'h00_0555, 8'ha0, 8'h00);
		issue(2'h1, 22'h01_0000, 8'h3c, 8'h00);
		wait_ready;
		repeat (6) @(negedge ref_clk);
		check({7'h00, busy_seen}, 8'h01, "busy level");
		issue(2'h0, 22'h01_0000, 8'h00, 8'h81);
		issue(2'h2, 22'h00_0000, 8'h00, 8'h01);
		issue(2'h0, 22'h01_0000, 8'h00, arr(22'h01_0000));
		// restart the aborted program
		issue(2'h1, 22'h00_0555, 8'ha0, 8'h00);
		issue(2'h1, 22'h01_0000, 8'h3c, 8'h00);
		wait_ready;
		for (i = 0; i < 500 && busy_seen !== 1'b0; i = i + 1) @(negedge ref_clk);
		issue(2'h3, 22'h00_0000, 8'h00, 8'h00);
		issue(2'h0, 22'h20_1234, 8'h00, arr(22'h20_1234));
		// sector then whole-array erase, polled while busy
		issue(2'h1, 22'h00_0555, 8'h80, 8'h00);
		issue(2'h1, 22'h2a_0000, 8'h30, 8'h00);
		issue(2'h0, 22'h2a_0000, 8'h00, 8'h2a);
		wait_ready;
		for (i = 0; i < 500 && busy_seen !== 1'b0; i = i + 1) @(negedge ref_clk);
		issue(2'h1, 22'h00_0555, 8'h80, 8'h00);
		issue(2'h1, 22'h15_0000, 8'h10, 8'h00);
		issue(2'h0, 22'h00_0000, 8'h00, 8'h15);
		wait_ready;
		for (i = 0; i < 500 && busy_seen !== 1'b0; i = i + 1) @(negedge ref_clk);
		issue(2'h0, 22'h2a_0000, 8'h00, arr(22'h2a_0000));
		wait_ready;
		repeat (20) @(negedge ref_clk);
		stop_test;
	end
endmodule

// ==== hw/fbo_ctl_regs.vh ====
`ifndef FBO_CTL_REGS_VH
`define FBO_CTL_REGS_VH

// clock period in ps (125 MHz)
`define FBO_CLK_PS          32'd8000
// bus timing figures in ns
`define FBO_ACC_NS          32'd90
`define FBO_WR_PULSE_NS     32'd45
`define FBO_WR_HOLD_NS      32'd20
`define FBO_CLEAR_PULSE_NS  32'd500
`define FBO_CLEAR_RECOV_NS  32'd50
// ready time after clear when busy, in us
`define FBO_READY_BUSY_US   32'd20
// cycle counts derived from the figures; least times round up
`define FBO_CYC_NS(ns)      (((ns) * 32'd1000 + `FBO_CLK_PS - 32'd1) / `FBO_CLK_PS)
`define FBO_ACC_CYC         `FBO_CYC_NS(`FBO_ACC_NS)
`define FBO_WR_PULSE_CYC    `FBO_CYC_NS(`FBO_WR_PULSE_NS)
`define FBO_WR_HOLD_CYC     `FBO_CYC_NS(`FBO_WR_HOLD_NS)
`define FBO_CLEAR_PULSE_CYC `FBO_CYC_NS(`FBO_CLEAR_PULSE_NS)
`define FBO_CLEAR_RECOV_CYC `FBO_CYC_NS(`FBO_CLEAR_RECOV_NS)
`define FBO_READY_BUSY_CYC  `FBO_CYC_NS(`FBO_READY_BUSY_US * 32'd1000)
// sector field of the address
`define FBO_SECTOR_MSB      21
`define FBO_SECTOR_LSB      16
// request kinds
`define FBO_OP_READ         2'h0
`define FBO_OP_WRITE        2'h1
`define FBO_OP_CLEAR        2'h2

`endif

// ==== hw/fbo_host.v ====
`timescale 1ns/1ps
`include "fbo_ctl_regs.vh"
// Notes on behaviour
// R1: read: select and output enable low, write strobe high.
// R2: write: select and write strobe low, output enable high.
// R3: device starts in array read after power-up or clear.
// R4: array read needs no preceding command.
// R5: command latch is unmapped; it holds command, address and data.
// R6: bad address, data or order returns the device to array read.
// R7: erase targets a sector, several sectors, or the whole device.
// R8: after identification sequence reads return identity codes.
// R9: during program or erase reads return status bits.
// R10: select and clear high put device in standby, outputs off.
// R11: after standby wait full select access time before sampling.
// R12: deselecting does not stop a running program or erase.
// R13: clear must be held low at least the minimum pulse width.
// R14: during clear the device ignores reads and writes.
// R15: clear returns device to array read, drops pending sequence.
// R16: clear low also places the device in standby.
// R17: host restarts an operation aborted by a clear; fbo_host does not restart it and only flags it on aborted_op.
// R18: clear during busy: ready_busy_n low until internal reset ends.
// R19: clear while idle completes within the shorter ready time.
// R20: wait recovery time after clear release before reading.
// R21: output enable high means data pins float.
// R22: sectors are 64 Kbytes chosen by the top six address bits.
// R23: elevated clear voltage allows writes as normal.
module fbo_host (
	ref_clk,        // 125 MHz clock
	reset,          // async reset, active high
	req_valid,      // request strobe, one cycle
	req_op,         // request kind
	req_addr,       // byte address
	req_wdata,      // write byte
	req_ready,      // idle, can take a request
	rsp_valid,      // read data or completion pulse
	rsp_rdata,      // read byte
	busy_seen,      // device reported busy
	aborted_op,     // clear hit a busy device
	address_pins,   // address to device
	data_pins_o,    // data driven to device
	data_pins_oe,   // high while host drives data
	data_pins_i,    // data from device
	chip_select_n,  // select, active low
	output_enable_n, // output enable, active low
	write_strobe_n, // write strobe, active low
	device_clear_n, // hardware reset pin, active low
	ready_busy_n    // ready/busy from device
);
	input  wire        ref_clk;         // clock
	input  wire        reset;           // reset
	input  wire        req_valid;       // request strobe
	input  wire [1:0]  req_op;          // request kind
	input  wire [21:0] req_addr;        // address
	input  wire [7:0]  req_wdata;       // write data
	output reg         req_ready;       // idle
	output reg         rsp_valid;       // answer pulse
	output reg  [7:0]  rsp_rdata;       // read data
	output reg         busy_seen;       // busy level
	output reg         aborted_op;      // abort flag
	output reg  [21:0] address_pins;    // address out
	output reg  [7:0]  data_pins_o;     // data out
	output reg         data_pins_oe;    // data enable
	input  wire [7:0]  data_pins_i;     // data in
	output reg         chip_select_n;   // select
	output reg         output_enable_n; // output enable
	output reg         write_strobe_n;  // write strobe
	output reg         device_clear_n;  // clear pin
	input  wire        ready_busy_n;    // ready/busy

	localparam [5:0] ST_IDLE  = 6'b000001;
	localparam [5:0] ST_RD    = 6'b000010;
	localparam [5:0] ST_WR    = 6'b000100;
	localparam [5:0] ST_WHOLD = 6'b001000;
	localparam [5:0] ST_CLR   = 6'b010000;
	localparam [5:0] ST_RECOV = 6'b100000;

	// counts come as 32-bit words; every one fits in 16 bits
	localparam [31:0] ACC_W     = `FBO_ACC_CYC;
	localparam [31:0] WRP_W     = `FBO_WR_PULSE_CYC;
	localparam [31:0] WRH_W     = `FBO_WR_HOLD_CYC;
	localparam [31:0] CLRP_W    = `FBO_CLEAR_PULSE_CYC;
	localparam [31:0] RECOV_W   = `FBO_CLEAR_RECOV_CYC;
	localparam [31:0] RDYB_W    = `FBO_READY_BUSY_CYC;
	localparam [15:0] ACC_CYC   = ACC_W[15:0];
	localparam [15:0] WRP_CYC   = WRP_W[15:0];
	localparam [15:0] WRH_CYC   = WRH_W[15:0];
	localparam [15:0] CLRP_CYC  = CLRP_W[15:0];
	localparam [15:0] RECOV_CYC = RECOV_W[15:0];
	localparam [15:0] RDYB_CYC  = RDYB_W[15:0];

	reg  [5:0]  state_reg;
	reg  [15:0] cnt_reg;
	reg  [7:0]  data_s1_reg;
	reg  [7:0]  data_s2_reg;
	reg  [7:0]  data_s3_reg;
	reg  [7:0]  data_lvl_reg;
	wire        ready_sync;

	// device pin is from outside our clock domain
	fbo_sync #(.INIT(1'b1)) u_rb_sync (
		.ref_clk   (ref_clk),
		.reset     (reset),
		.pin_in    (ready_busy_n),
		.level_out (ready_sync)
	);

	// byte counts once stages two and three agree; costs four extra cycles
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			data_s1_reg  <= 8'h00;
			data_s2_reg  <= 8'h00;
			data_s3_reg  <= 8'h00;
			data_lvl_reg <= 8'h00;
		end else begin
			data_s1_reg <= data_pins_i;
			data_s2_reg <= data_s1_reg;
			data_s3_reg <= data_s2_reg;
			if (data_s2_reg == data_s3_reg)
				data_lvl_reg <= data_s3_reg;
		end
	end

	function [15:0] dec;
		input [15:0] v;
		begin
			dec = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
		end
	endfunction

	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_reg       <= ST_CLR;
			cnt_reg         <= CLRP_CYC;
			req_ready       <= 1'b0;
			rsp_valid       <= 1'b0;
			rsp_rdata       <= 8'h00;
			busy_seen       <= 1'b0;
			aborted_op      <= 1'b0;
			address_pins    <= 22'h00_0000;
			data_pins_o     <= 8'h00;
			data_pins_oe    <= 1'b0;
			chip_select_n   <= 1'b1;
			output_enable_n <= 1'b1;
			write_strobe_n  <= 1'b1;
			device_clear_n  <= 1'b0;  // see R3
		end else begin
			rsp_valid <= 1'b0;
			// status survives deselect; host keeps watching it  see R12
			busy_seen <= ~ready_sync;
			cnt_reg   <= dec(cnt_reg);
			case (state_reg)
			ST_IDLE: begin
				if (req_valid) begin
					req_ready    <= 1'b0;
					address_pins <= req_addr;
					case (req_op)
					`FBO_OP_READ: begin
						// full select access time from standby  see R11
						chip_select_n   <= 1'b0;  // see R1
						output_enable_n <= 1'b0;
						write_strobe_n  <= 1'b1;
						// plus the latency of the data filter
						cnt_reg         <= ACC_CYC + 16'h0004;
						state_reg       <= ST_RD;
					end
					`FBO_OP_WRITE: begin
						// data floats in device since oe is high  see R21
						chip_select_n   <= 1'b0;  // see R2
						output_enable_n <= 1'b1;
						write_strobe_n  <= 1'b0;
						data_pins_o     <= req_wdata;
						data_pins_oe    <= 1'b1;
						cnt_reg         <= WRP_CYC;
						state_reg       <= ST_WR;
					end
					default: begin
						// aborted work must be redone by software  see R17
						aborted_op     <= ~ready_sync;
						device_clear_n <= 1'b0;  // see R15
						cnt_reg        <= CLRP_CYC;
						state_reg      <= ST_CLR;
					end
					endcase
				end
			end
			ST_RD: begin
				if (cnt_reg == 16'h0000) begin
					// array, identity or status byte alike  see R4
					rsp_rdata       <= data_lvl_reg;  // see R9
					rsp_valid       <= 1'b1;
					chip_select_n   <= 1'b1;  // see R10
					output_enable_n <= 1'b1;
					req_ready       <= 1'b1;
					state_reg       <= ST_IDLE;
				end
			end
			ST_WR: begin
				if (cnt_reg == 16'h0000) begin
					// rising strobe latches the command  see R5
					write_strobe_n <= 1'b1;
					cnt_reg        <= WRH_CYC;
					state_reg      <= ST_WHOLD;
				end
			end
			ST_WHOLD: begin
				if (cnt_reg == 16'h0000) begin
					chip_select_n <= 1'b1;
					data_pins_oe  <= 1'b0;
					rsp_valid     <= 1'b1;
					req_ready     <= 1'b1;
					state_reg     <= ST_IDLE;
				end
			end
			ST_CLR: begin
				// pulse held its minimum only; a busy device's internal
				// reset is waited out later in ST_RECOV  see R13
				if (cnt_reg == 16'h0000) begin
					device_clear_n <= 1'b1;  // see R16
					cnt_reg        <= RDYB_CYC;
					state_reg      <= ST_RECOV;
				end
			end
			ST_RECOV: begin
				// recovery time, then ready; the busy ready time
				// bounds the wait so a stuck pin cannot hang us  see R18
				if (((RDYB_CYC - cnt_reg) >= RECOV_CYC && ready_sync) ||
					cnt_reg == 16'h0000) begin  // see R20
					rsp_valid  <= 1'b1;
					req_ready  <= 1'b1;
					state_reg  <= ST_IDLE;
				end
			end
			default: begin
				state_reg <= ST_IDLE;
				req_ready <= 1'b1;
			end
			endcase
		end
	end

endmodule

// ==== hw/fbo_sync.v ====
`timescale 1ns/1ps
// three-stage synchroniser; change accepted when stages two and three agree
module fbo_sync (
	ref_clk,   // clock
	reset,     // async reset, active high
	pin_in,    // raw pin
	level_out  // filtered level
);
	parameter INIT = 1'b1;
	input  wire ref_clk;   // clock
	input  wire reset;     // async reset
	input  wire pin_in;    // raw pin
	output reg  level_out; // filtered level

	reg s1_reg;
	reg s2_reg;
	reg s3_reg;

	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			s1_reg    <= INIT;
			s2_reg    <= INIT;
			s3_reg    <= INIT;
			level_out <= INIT;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
				level_out <= s3_reg;
		end
	end
endmodule
